// [testbench/tb.sv]
// Self-checking bench for the buffered timer/PWM block
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        ext_tick;
    logic        background_debug_mode;
    logic        pwm_out;
    logic        pwm_oe_n;
    logic        irq;
    int          errors;
    int          comparisons;

    tpmb_timer_pwm #(.ADDR_W(8)) tpmb_timer_pwm_inst (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ext_tick, .background_debug_mode, .pwm_out, .pwm_oe_n, .irq);

    // ==========================================================
    // Clock, 200 MHz
    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Watchdog at 20000 cycles, well past the fewer than one thousand cycles the tests need
    initial
    begin
        #100000;
        errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end

    // ==========================================================
    // Shared helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // Offsets at 0x1c and above are unmapped, and they answer with an error
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1 || n > 50) break;
            n++;
        end
        check(s_axi_bvalid, 1'b1);
        check(s_axi_bresp, (a < 8'h1c) ? tpmb_pkg::RESP_OKAY : tpmb_pkg::RESP_SLVERR);
        s_axi_bready  <= 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1 || n > 50) break;
            n++;
        end
        d = s_axi_rdata;
        check(s_axi_rvalid, 1'b1);
        check(s_axi_rresp, (a < 8'h1c) ? tpmb_pkg::RESP_OKAY : tpmb_pkg::RESP_SLVERR);
        s_axi_rready  <= 1'b0;
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
    endtask

    // Any whole period of a steady waveform holds exactly its duty count
    task automatic window(input int n, output int k);
        k = 0;
        repeat (n)
        begin
            @(posedge aclk);
            if (pwm_out === 1'b1) k++;
        end
    endtask

    // Cycles between two rising edges of the pin, capped at 200 only once the first edge has been seen
    task automatic period(output int p);
        logic prev;
        int   n;
        p = 0;
        n = 0;
        prev = pwm_out;
        while (n < 2 && p < 200)
        begin
            @(posedge aclk);
            if (n == 1) p++;
            if (pwm_out === 1'b1 && prev === 1'b0) n++;
            prev = pwm_out;
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [31:0] d;
        rd(tpmb_pkg::ADDR_TSC, d);
        check(d, 32'h0);
        rd(tpmb_pkg::ADDR_IMK, d);
        check(d, 32'h0);
        rd(8'h1c, d);
        check(d, 32'h0);
        wr(8'h1c, 32'hffffffff, 4'hf);
        check(pwm_oe_n, 1'b1);
        check(irq, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_freeze();
        logic [31:0] d;
        int          k;
        wr(tpmb_pkg::ADDR_MOD, 32'h7, 4'h3);
        wr(tpmb_pkg::ADDR_CHV, 32'h5, 4'h3);
        wr(tpmb_pkg::ADDR_CHC, 32'h6, 4'h1);
        repeat (2) @(posedge aclk);
        check(pwm_oe_n, 1'b0);
        window(16, k);
        check(k, 0);
        rd(tpmb_pkg::ADDR_CHV, d);
        check(d, 32'h5);
        $display("test freeze done");
    endtask

    task automatic t_edge();
        logic [31:0] d;
        logic        v;
        int          k;
        int          p;
        wr(tpmb_pkg::ADDR_TSC, 32'h1, 4'h1);
        repeat (16) @(posedge aclk);
        window(8, k);
        check(k, 5);
        period(p);
        check(p, 8);
        // Low byte alone must not reach the active value
        wr(tpmb_pkg::ADDR_CHV, 32'h3, 4'h1);
        repeat (24) @(posedge aclk);
        window(8, k);
        check(k, 5);
        rd(tpmb_pkg::ADDR_CHV, d);
        check(d, 32'h5);
        wr(tpmb_pkg::ADDR_CHV, 32'h0, 4'h2);
        repeat (24) @(posedge aclk);
        window(8, k);
        check(k, 3);
        rd(tpmb_pkg::ADDR_CHV, d);
        check(d, 32'h3);
        // Stop the clock in mid-run, then touch the channel control
        wr(tpmb_pkg::ADDR_TSC, 32'h0, 4'h1);
        wr(tpmb_pkg::ADDR_CHC, 32'h6, 4'h1);
        v = pwm_out;
        window(16, k);
        check(k, (v === 1'b1) ? 16 : 0);
        $display("test edge done");
    endtask

    task automatic t_center();
        int k;
        int p;
        wr(tpmb_pkg::ADDR_TSC, 32'h5, 4'h1);
        repeat (40) @(posedge aclk);
        period(p);
        check(p, 14);
        wr(tpmb_pkg::ADDR_CHV, 32'h7, 4'h3);
        repeat (40) @(posedge aclk);
        window(14, k);
        check(k, 14);
        wr(tpmb_pkg::ADDR_CHV, 32'h6, 4'h3);
        repeat (40) @(posedge aclk);
        window(14, k);
        check(k, 11);
        wr(tpmb_pkg::ADDR_CHV, 32'h0, 4'h3);
        repeat (40) @(posedge aclk);
        window(14, k);
        check(k, 0);
        wr(tpmb_pkg::ADDR_CHV, 32'h7, 4'h3);
        repeat (40) @(posedge aclk);
        window(14, k);
        check(k, 14);
        wr(tpmb_pkg::ADDR_CHV, 32'h3, 4'h1);
        repeat (40) @(posedge aclk);
        window(14, k);
        check(k, 14);
        wr(tpmb_pkg::ADDR_CHV, 32'h0, 4'h2);
        repeat (40) @(posedge aclk);
        window(14, k);
        check(k, 5);
        $display("test center done");
    endtask

    task automatic t_irq();
        logic [31:0] d;
        wr(tpmb_pkg::ADDR_IMK, 32'h1, 4'h1);
        repeat (20) @(posedge aclk);
        check(irq, 1'b1);
        rd(tpmb_pkg::ADDR_IST, d);
        check(d[0], 1'b1);
        wr(tpmb_pkg::ADDR_IMK, 32'h0, 4'h1);
        repeat (2) @(posedge aclk);
        check(irq, 1'b0);
        // With the clock off no new event can refill the status
        wr(tpmb_pkg::ADDR_TSC, 32'h0, 4'h1);
        rd(tpmb_pkg::ADDR_IST, d);
        rd(tpmb_pkg::ADDR_IST, d);
        check(d, 32'h0);
        wr(tpmb_pkg::ADDR_IMK, 32'h3, 4'h1);
        repeat (2) @(posedge aclk);
        check(irq, 1'b0);
        wr(tpmb_pkg::ADDR_IMK, 32'h0, 4'h1);
        $display("test irq done");
    endtask

    task automatic t_debug();
        logic [31:0] d;
        background_debug_mode <= 1'b1;
        wr(tpmb_pkg::ADDR_MOD, 32'h9, 4'h1);
        wr(tpmb_pkg::ADDR_TSC, 32'h0, 4'h1);
        wr(tpmb_pkg::ADDR_MOD, 32'h0, 4'h2);
        rd(tpmb_pkg::ADDR_MOD, d);
        check(d, 32'h7);
        wr(tpmb_pkg::ADDR_MOD, 32'h9, 4'h1);
        rd(tpmb_pkg::ADDR_MOD, d);
        check(d, 32'h9);
        // Outside debug the same control write leaves the partial byte alone
        background_debug_mode <= 1'b0;
        wr(tpmb_pkg::ADDR_MOD, 32'ha, 4'h1);
        wr(tpmb_pkg::ADDR_TSC, 32'h0, 4'h1);
        wr(tpmb_pkg::ADDR_MOD, 32'h0, 4'h2);
        rd(tpmb_pkg::ADDR_MOD, d);
        check(d, 32'ha);
        $display("test debug done");
    endtask

    // Start-up with the pin released, on the external tick with divide by two
    task automatic t_start();
        logic [31:0] d;
        int          k;
        int          p;
        int          n;
        wr(tpmb_pkg::ADDR_CHC, 32'h4, 4'h1);
        wr(tpmb_pkg::ADDR_CNT, 32'h0, 4'h1);
        wr(tpmb_pkg::ADDR_TSC, 32'hb, 4'h1);
        repeat (8) @(posedge aclk);
        rd(tpmb_pkg::ADDR_CNT, d);
        check(d, 32'h0);
        ext_tick <= 1'b1;
        d = 32'h0;
        n = 0;
        while (d[0] !== 1'b1 && n < 20)
        begin
            rd(tpmb_pkg::ADDR_IST, d);
            n++;
        end
        check(d[0], 1'b1);
        check(pwm_oe_n, 1'b1);
        wr(tpmb_pkg::ADDR_CHC, 32'h6, 4'h1);
        check(pwm_oe_n, 1'b0);
        period(p);
        check(p, 22);
        window(22, k);
        check(k, 6);
        ext_tick <= 1'b0;
        $display("test start done");
    endtask

    task automatic conclude();
        $display("comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        errors = 0;
        comparisons = 0;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        ext_tick = 1'b0;
        background_debug_mode = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_freeze();
        t_edge();
        t_center();
        t_irq();
        t_debug();
        t_start();
        conclude();
    end
endmodule

`default_nettype wire

// [verilog/tpmb_pkg.sv]
// Package of register map, field layouts and constants for the buffered timer/PWM block
package tpmb_pkg;

    // ==========================================================
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] ADDR_TSC = 8'h00; // timer_status_control
    localparam logic [7:0] ADDR_CNT = 8'h04; // Counter, write clears
    localparam logic [7:0] ADDR_MOD = 8'h08; // modulo_value
    localparam logic [7:0] ADDR_CHC = 8'h0c; // channel_status_control
    localparam logic [7:0] ADDR_CHV = 8'h10; // channel_value
    localparam logic [7:0] ADDR_IST = 8'h14; // Interrupt status, read clears
    localparam logic [7:0] ADDR_IMK = 8'h18; // Interrupt mask

    // ==========================================================
    // Encodings and counter values
    localparam logic [1:0]  CLKS_OFF    = 2'h0;
    localparam logic [1:0]  CLKS_EXT    = 2'h3;
    localparam logic [1:0]  ELS_OFF     = 2'h0;
    localparam logic [15:0] FREE_TOP    = 16'hffff;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ==========================================================
    // Field layouts: timer control bits 5:3 prescale, 2 center, 1:0 clock source
    typedef struct packed {
        logic [2:0] prescale;
        logic       center_aligned;
        logic [1:0] clock_source_select;
    } tpmb_tsc_t;

    // Channel control bits 2 edge_aligned_pwm, 1:0 edge_level_select
    typedef struct packed {
        logic       edge_aligned_pwm;
        logic [1:0] edge_level_select;
    } tpmb_chc_t;

    // Interrupt status and mask bits 1 channel match, 0 overflow_flag
    typedef struct packed {
        logic channel_match;
        logic overflow_flag;
    } tpmb_irq_t;

    // ==========================================================
    // Reset values
    localparam tpmb_tsc_t TSC_RST = '0;
    localparam tpmb_chc_t CHC_RST = '0;
    localparam tpmb_irq_t IRQ_RST = '0;
    localparam logic [15:0] MOD_RST = 16'h0000;
    localparam logic [15:0] CHV_RST = 16'h0000;
    localparam logic [6:0]  PS_RST  = 7'h00;

endpackage

// [verilog/tpmb_timer_pwm.sv]
// Single-channel 16-bit timer/PWM with buffered channel value and AXI4-Lite registers
// Operation
// - Edge PWM: buffered value loads after both bytes, on step modulo-1 to modulo
// - Center PWM, clock on: buffered value loads after both bytes, same step
// - Center PWM with channel value equal to modulo gives full duty
// - Center PWM with channel value modulo minus one gives almost full duty
// - Center PWM change from zero applies only at a new period
// - Center PWM change to zero finishes current period with old duty
// - Timer control write in debug mode clears modulo byte coherency latch
// - With clock source off the PWM pin output stays frozen
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tpmb_timer_pwm #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              ext_tick,
    input  wire logic              background_debug_mode,
    output logic                   pwm_out,
    output logic                   pwm_oe_n,
    output logic                   irq
);
    // ==========================================================
    // Helpers
    function automatic logic [6:0] ps_mask(input logic [2:0] ps);
        ps_mask = 7'((8'h01 << ps) - 8'h01);
    endfunction
    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        addr_is = (a[7:0] == off);
    endfunction
    // ==========================================================
    // State
    tpmb_pkg::tpmb_tsc_t tsc_q;
    tpmb_pkg::tpmb_chc_t chc_q;
    tpmb_pkg::tpmb_irq_t ist_q, ist_d, imk_q;
    logic [15:0] mod_q, mod_buf_q, cnt_q, chv_q, chv_buf_q;
    logic [6:0]  ps_cnt_q;
    logic        up_q, mod_lo_w_q, mod_hi_w_q, chv_lo_w_q, chv_hi_w_q;
    logic        aw_full_q, w_full_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic        pwm_out_q, pwm_oe_n_q, irq_q;
    // ==========================================================
    // Bus decode
    wire do_write = aw_full_q && w_full_q && !bvalid_q;
    wire do_read  = s_axi_arvalid && arready_q;
    wire wr_tsc   = do_write && addr_is(awaddr_q, tpmb_pkg::ADDR_TSC);
    wire wr_cnt   = do_write && addr_is(awaddr_q, tpmb_pkg::ADDR_CNT);
    wire wr_mod   = do_write && addr_is(awaddr_q, tpmb_pkg::ADDR_MOD);
    wire wr_chc   = do_write && addr_is(awaddr_q, tpmb_pkg::ADDR_CHC);
    wire wr_chv   = do_write && addr_is(awaddr_q, tpmb_pkg::ADDR_CHV);
    wire wr_imk   = do_write && addr_is(awaddr_q, tpmb_pkg::ADDR_IMK);
    wire wr_ist   = do_write && addr_is(awaddr_q, tpmb_pkg::ADDR_IST);
    wire wr_hit   = wr_tsc || wr_cnt || wr_mod || wr_chc || wr_chv || wr_imk || wr_ist;
    wire rd_ist   = do_read && addr_is(s_axi_araddr, tpmb_pkg::ADDR_IST);
    // Read data mux, unmapped reads give zero with an error
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb
    begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr[7:0])
            tpmb_pkg::ADDR_TSC: rd_mux = {26'h0, tsc_q};
            tpmb_pkg::ADDR_CNT: rd_mux = {16'h0, cnt_q};
            tpmb_pkg::ADDR_MOD: rd_mux = {16'h0, mod_q};
            tpmb_pkg::ADDR_CHC: rd_mux = {29'h0, chc_q};
            tpmb_pkg::ADDR_CHV: rd_mux = {16'h0, chv_q};
            tpmb_pkg::ADDR_IST: rd_mux = {30'h0, ist_q};
            tpmb_pkg::ADDR_IMK: rd_mux = {30'h0, imk_q};
            default:            rd_hit = 1'b0;
        endcase
    end
    // ==========================================================
    // Prescaler and counter stepping
    wire clks_off = (tsc_q.clock_source_select == tpmb_pkg::CLKS_OFF);
    wire src_en   = clks_off ? 1'b0 :
                    (tsc_q.clock_source_select == tpmb_pkg::CLKS_EXT) ? ext_tick : 1'b1;
    wire tick     = src_en && ((ps_cnt_q & ps_mask(tsc_q.prescale)) == ps_mask(tsc_q.prescale));
    wire center   = tsc_q.center_aligned;
    wire [15:0] top = (mod_q == 16'h0000) ? tpmb_pkg::FREE_TOP : mod_q;
    wire at_top   = (cnt_q == top);
    wire up_eff   = !center || up_q;
    wire load_step = tick && up_eff && (cnt_q == 16'(top - 16'h0001));
    wire chv_both = chv_lo_w_q && chv_hi_w_q;
    wire chv_load = chv_both && (clks_off || load_step);
    wire tof_set  = tick && at_top && up_eff;
    wire chm_set  = tick && (cnt_q == chv_q);
    wire        turn_up = center && !up_q && (cnt_q == 16'h0000);
    wire        step_up = !center || (up_q && !at_top) || turn_up;
    wire [15:0] cnt_d   = (!center && at_top) ? 16'h0000 :
                          step_up ? 16'(cnt_q + 16'h0001) : 16'(cnt_q - 16'h0001);
    wire        up_d    = !center || (up_q ? !at_top : turn_up);
    // Counter and prescaler; a counter write clears both
    always_ff @(posedge aclk)
    begin
        if (!aresetn || wr_cnt)
        begin
            cnt_q    <= 16'h0000;
            up_q     <= 1'b1;
            ps_cnt_q <= tpmb_pkg::PS_RST;
        end
        else
        begin
            if (src_en)
                ps_cnt_q <= 7'(ps_cnt_q + 7'h01);
            if (tick)
            begin
                cnt_q <= cnt_d;
                up_q  <= up_d;
            end
        end
    end
    // ==========================================================
    // Control registers and modulo coherency
    wire mod_lo = wr_mod && wstrb_q[0];
    wire mod_hi = wr_mod && wstrb_q[1];
    wire mod_done = (mod_lo || mod_lo_w_q) && (mod_hi || mod_hi_w_q);
    wire mod_latch_clr = wr_tsc && background_debug_mode;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tsc_q <= tpmb_pkg::TSC_RST;
            chc_q <= tpmb_pkg::CHC_RST;
            imk_q <= tpmb_pkg::IRQ_RST;
            mod_q <= tpmb_pkg::MOD_RST;
            mod_buf_q <= tpmb_pkg::MOD_RST;
            mod_lo_w_q <= 1'b0;
            mod_hi_w_q <= 1'b0;
        end
        else
        begin
            if (wr_tsc && wstrb_q[0]) tsc_q <= wdata_q[5:0];
            if (wr_chc && wstrb_q[0]) chc_q <= wdata_q[2:0];
            if (wr_imk && wstrb_q[0]) imk_q <= wdata_q[1:0];
            if (mod_lo) mod_buf_q[7:0]  <= wdata_q[7:0];
            if (mod_hi) mod_buf_q[15:8] <= wdata_q[15:8];
            if (mod_done)
                mod_q <= {mod_hi ? wdata_q[15:8] : mod_buf_q[15:8],
                          mod_lo ? wdata_q[7:0]  : mod_buf_q[7:0]};
            mod_lo_w_q <= !(mod_done || mod_latch_clr) && (mod_lo_w_q || mod_lo);
            mod_hi_w_q <= !(mod_done || mod_latch_clr) && (mod_hi_w_q || mod_hi);
        end
    end
    // ==========================================================
    // Buffered channel value; loads at the period boundary, or at once with the clock source off
    wire chv_lo = wr_chv && wstrb_q[0];
    wire chv_hi = wr_chv && wstrb_q[1];
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            chv_q      <= tpmb_pkg::CHV_RST;
            chv_buf_q  <= tpmb_pkg::CHV_RST;
            chv_lo_w_q <= 1'b0;
            chv_hi_w_q <= 1'b0;
        end
        else
        begin
            if (chv_lo) chv_buf_q[7:0]  <= wdata_q[7:0];
            if (chv_hi) chv_buf_q[15:8] <= wdata_q[15:8];
            if (chv_load)
                chv_q <= chv_buf_q;
            chv_lo_w_q <= (chv_lo_w_q && !chv_load) || chv_lo;
            chv_hi_w_q <= (chv_hi_w_q && !chv_load) || chv_hi;
        end
    end
    // ==========================================================
    // Channel waveform; level compares keep zero duty glitch free
    wire edge_aligned_pwm_lvl = (cnt_q < chv_q);
    wire cpwm_lvl = (cnt_q < chv_q) || (chv_q == top);
    wire pwm_lvl  = center ? cpwm_lvl : (chc_q.edge_aligned_pwm ? edge_aligned_pwm_lvl : 1'b0);
    wire els_off  = (chc_q.edge_level_select == tpmb_pkg::ELS_OFF);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwm_out_q  <= 1'b0;
            pwm_oe_n_q <= 1'b1;
        end
        else
        begin
            pwm_oe_n_q <= els_off;
            if (!clks_off)
                pwm_out_q <= pwm_lvl ^ chc_q.edge_level_select[0];
        end
    end
    // ==========================================================
    // Sticky interrupt status; a new event beats the read clear
    assign ist_d = (rd_ist ? tpmb_pkg::IRQ_RST : ist_q) | {chm_set, tof_set};
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ist_q <= tpmb_pkg::IRQ_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            ist_q <= ist_d;
            irq_q <= |(ist_q & imk_q);
        end
    end
    // ==========================================================
    // AXI4-Lite write channels, address and data in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= tpmb_pkg::RESP_OKAY;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && awready_q)
            begin
                aw_full_q <= 1'b1;
                awready_q <= 1'b0;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q)
            begin
                w_full_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_write)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? tpmb_pkg::RESP_OKAY : tpmb_pkg::RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready)
            begin
                bvalid_q  <= 1'b0;
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end
    // Read channel, data registered at the address handshake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= tpmb_pkg::RESP_OKAY;
        end
        else if (do_read)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_mux;
            rresp_q   <= rd_hit ? tpmb_pkg::RESP_OKAY : tpmb_pkg::RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end
    // Outputs straight from flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign pwm_out       = pwm_out_q;
    assign pwm_oe_n      = pwm_oe_n_q;
    assign irq           = irq_q;
    // ==========================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_chv_load_time: assert property ($changed(chv_q) |-> $past(chv_load))
        else $error("channel value changed outside load point");
    a_edge_load_top: assert property (!center && load_step && chv_both && !wr_cnt
        |=> cnt_q == top && chv_q == $past(chv_buf_q))
        else $error("edge load not at modulo step");
    a_cpwm_load_peak: assert property (center && load_step && chv_both && !wr_cnt
        |=> up_q == 1'b0 || cnt_q == top)
        else $error("center load not at peak");
    a_cpwm_full: assert property (center && !clks_off && chv_q == top
        && chc_q.edge_level_select == 2'h2 |=> pwm_out_q)
        else $error("full duty not held");
    a_cpwm_near_full: assert property (center && !clks_off && chv_q == 16'(top - 16'h0001)
        && cnt_q < chv_q && chc_q.edge_level_select == 2'h2 |=> pwm_out_q)
        else $error("almost full duty missing");
    a_cpwm_zero: assert property (center && !clks_off && chv_q == 16'h0000
        && chc_q.edge_level_select == 2'h2 |=> !pwm_out_q)
        else $error("zero duty produced a pulse");
    a_zero_hold: assert property ($past(chv_q) == 16'h0000 && chv_q != 16'h0000
        |-> $past(clks_off || load_step))
        else $error("left zero mid period");
    a_bdm_latch_clr: assert property (wr_tsc && background_debug_mode
        |=> !mod_lo_w_q && !mod_hi_w_q)
        else $error("modulo latch survived debug write");
    a_edge_aligned_pwm_frozen: assert property ($past(clks_off) |-> $stable(pwm_out_q))
        else $error("output moved with clock off");
    a_cpwm_bounce: assert property (center && tick && !wr_cnt && up_q && at_top
        |=> !up_q && cnt_q == 16'($past(cnt_q) - 16'h0001))
        else $error("no turn at top");
    a_cpwm_bottom: assert property (center && tick && !wr_cnt && !up_q && cnt_q == 16'h0000
        |=> up_q && cnt_q == 16'h0001)
        else $error("no turn at bottom");
    a_irq_level: assert property (irq_q == $past(|(ist_q & imk_q)))
        else $error("interrupt level mismatch");
    a_write_resp: assert property (do_write |=> bvalid_q)
        else $error("write response late");
    c_full_duty: cover property (center && chv_q == top && tick);
    c_center_load: cover property (center && chv_load && !clks_off);
    c_irq_raise: cover property (!irq_q ##1 irq_q);
    c_overflow: cover property (tof_set && !center);
endmodule
`default_nettype wire
